/* logic/irc_pkg.sv */
// package for the isochronous receive context control and status block
package irc_pkg;
	localparam int NUM_CTX = 4;
	localparam logic [11:0] OFS_CTL_SET = 12'h400;
	localparam logic [11:0] OFS_CTL_CLR = 12'h404;
	localparam logic [11:0] OFS_CMD_PTR = 12'h40C;
	localparam logic [11:0] CTX_STRIDE = 12'h020;
	localparam int BIT_FILL = 31;
	localparam int BIT_RUN = 15;
	localparam int BIT_WAKE = 12;
	localparam int BIT_HALT = 11;
	localparam int BIT_ACTIVE = 10;
	localparam int BIT_BETA = 9;
	localparam int SPD_LSB = 5;
	localparam int EVT_LSB = 0;
	localparam logic [2:0] SPD_100 = 3'h0;
	localparam logic [2:0] SPD_200 = 3'h1;
	localparam logic [2:0] SPD_400 = 3'h2;
	localparam logic [2:0] SPD_800 = 3'h3;
	localparam logic [4:0] EVT_NONE = 5'h00;
	localparam logic [4:0] EVT_LONG_PACKET = 5'h02;
	localparam logic [4:0] EVT_DESC_READ = 5'h04;
	localparam logic [4:0] EVT_DATA_WRITE = 5'h06;
	localparam logic [4:0] EVT_OVERRUN = 5'h08;
	localparam logic [4:0] EVT_UNKNOWN = 5'h0E;
	localparam logic [4:0] ACK_COMPLETE = 5'h11;
	localparam logic [4:0] ACK_DATA_ERROR = 5'h1D;
	localparam logic [31:0] CMD_PTR_RESET = 32'h0000_0000;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} irc_bus_req_t;

	// one packet completion report from the receive data path
	typedef struct packed {
		logic valid;
		logic [1:0] ctx;
		logic beta;
		logic [2:0] speed;
		logic len_err;
		logic crc_err;
		logic overrun;
		logic long_pkt;
	} irc_pkt_t;

	// engine-side events per context
	typedef struct packed {
		logic fetch;
		logic fatal;
		logic [4:0] fatal_code;
		logic idle;
		logic [31:0] ptr;
		logic ptr_load;
	} irc_eng_t;

	typedef struct packed {
		logic run;
		logic wake;
		logic halt;
		logic active;
		logic beta;
		logic [2:0] speed;
		logic [4:0] evt;
		logic fill;
		logic [31:0] ptr;
	} irc_ctx_t;

	typedef enum logic [1:0] {
		IRC_IDLE = 2'b00,
		IRC_ACTIVE = 2'b01,
		IRC_HALTED = 2'b11
	} irc_state_t;
endpackage

/* logic/irc_ctx.sv */
// one isochronous receive context: control flags, status and state machine
`timescale 1ns/1ps
module irc_ctx (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic sw_rst,
	input wire logic set_wr,
	input wire logic clr_wr,
	input wire logic [31:0] wdata,
	input wire irc_pkg::irc_pkt_t pkt,
	input wire irc_pkg::irc_eng_t eng,
	output irc_pkg::irc_ctx_t ctx_q,
	output irc_pkg::irc_state_t state_q,
	output logic resp_beta
);
	typedef struct packed {
		irc_pkg::irc_ctx_t c;
		irc_pkg::irc_state_t st;
	} irc_cst_t;

	irc_cst_t st_ff;
	irc_cst_t nxt_st;
	logic run_rise;
	logic run_fall;

	always_comb begin
		nxt_st = st_ff;
		run_rise = set_wr && wdata[irc_pkg::BIT_RUN] && !st_ff.c.run;
		run_fall = clr_wr && wdata[irc_pkg::BIT_RUN] && st_ff.c.run;
		if (set_wr) begin
			if (wdata[irc_pkg::BIT_RUN])
				nxt_st.c.run = 1'b1;
			if (wdata[irc_pkg::BIT_WAKE])
				nxt_st.c.wake = 1'b1;
			if (wdata[irc_pkg::BIT_FILL] && !st_ff.c.run && !st_ff.c.active)
				nxt_st.c.fill = 1'b1;
		end
		if (clr_wr) begin
			if (wdata[irc_pkg::BIT_RUN])
				nxt_st.c.run = 1'b0;
			if (wdata[irc_pkg::BIT_FILL] && !st_ff.c.run && !st_ff.c.active)
				nxt_st.c.fill = 1'b0;
		end
		if (run_fall)
			nxt_st.c.halt = 1'b0;
		if (eng.ptr_load && !st_ff.c.run)
			nxt_st.c.ptr = eng.ptr;
		if (eng.fetch && st_ff.st == irc_pkg::IRC_ACTIVE &&
				!(set_wr && wdata[irc_pkg::BIT_WAKE]))
			nxt_st.c.wake = 1'b0;
		case (st_ff.st)
			irc_pkg::IRC_IDLE: begin
				if (run_rise)
					nxt_st.st = irc_pkg::IRC_ACTIVE;
			end
			irc_pkg::IRC_ACTIVE: begin
				if (!nxt_st.c.run)
					nxt_st.st = irc_pkg::IRC_IDLE;
				else if (eng.fatal) begin
					nxt_st.c.halt = 1'b1;
					nxt_st.c.evt = eng.fatal_code;
					nxt_st.st = irc_pkg::IRC_HALTED;
				end else if (eng.idle && !nxt_st.c.wake)
					nxt_st.st = irc_pkg::IRC_IDLE;
			end
			irc_pkg::IRC_HALTED: begin
				if (!nxt_st.c.run)
					nxt_st.st = irc_pkg::IRC_IDLE;
			end
			default: nxt_st.st = irc_pkg::IRC_IDLE;
		endcase
		if (st_ff.st == irc_pkg::IRC_IDLE && st_ff.c.run && st_ff.c.wake &&
				!st_ff.c.halt)
			nxt_st.st = irc_pkg::IRC_ACTIVE;
		nxt_st.c.active = (nxt_st.st == irc_pkg::IRC_ACTIVE);
		if (pkt.valid && st_ff.st == irc_pkg::IRC_ACTIVE) begin
			nxt_st.c.beta = pkt.beta;
			nxt_st.c.speed = pkt.speed;
			if (st_ff.c.fill) begin
				if (pkt.len_err || pkt.crc_err || pkt.overrun)
					nxt_st.c.evt = st_ff.c.evt;
				else
					nxt_st.c.evt = irc_pkg::ACK_COMPLETE;
			end else begin
				if (pkt.overrun)
					nxt_st.c.evt = irc_pkg::EVT_OVERRUN;
				else if (pkt.long_pkt)
					nxt_st.c.evt = irc_pkg::EVT_LONG_PACKET;
				else if (pkt.len_err || pkt.crc_err)
					nxt_st.c.evt = irc_pkg::ACK_DATA_ERROR;
				else
					nxt_st.c.evt = irc_pkg::ACK_COMPLETE;
			end
		end
		if (sw_rst) begin
			nxt_st.c.run = 1'b0;
			nxt_st.c.wake = 1'b0;
			nxt_st.c.halt = 1'b0;
			nxt_st.c.active = 1'b0;
			nxt_st.st = irc_pkg::IRC_IDLE;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_ff <= '0;
			st_ff.c.ptr <= irc_pkg::CMD_PTR_RESET;
			st_ff.c.evt <= irc_pkg::EVT_NONE;
			st_ff.st <= irc_pkg::IRC_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign ctx_q = st_ff.c;
	assign state_q = st_ff.st;
	assign resp_beta = st_ff.c.beta;

	run_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(!set_wr && !clr_wr && !sw_rst) |=> $stable(st_ff.c.run))
		else $error("run changed without software");
	halt_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		run_fall |=> !st_ff.c.halt)
		else $error("halt not cleared with run");
	active_run_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		st_ff.c.active |-> st_ff.c.run)
		else $error("active without run");
	wake_fetch_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(eng.fetch && st_ff.st == irc_pkg::IRC_ACTIVE && !set_wr && !sw_rst)
		|=> !st_ff.c.wake)
		else $error("wake not cleared on fetch");
	fatal_halt_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(eng.fatal && st_ff.st == irc_pkg::IRC_ACTIVE && nxt_st.c.run && !sw_rst)
		|=> st_ff.c.halt && !st_ff.c.active)
		else $error("fatal did not halt");
	start_run_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(run_rise && !sw_rst) |=> st_ff.c.active)
		else $error("run did not start context");
	fill_code_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(pkt.valid && st_ff.c.fill && st_ff.st == irc_pkg::IRC_ACTIVE && !eng.fatal
		&& (pkt.crc_err || pkt.len_err || pkt.overrun)) |=> $stable(st_ff.c.evt))
		else $error("bad packet not backed out");
	beta_rx_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(pkt.valid && st_ff.st == irc_pkg::IRC_ACTIVE && !sw_rst)
		|=> st_ff.c.beta == $past(pkt.beta))
		else $error("beta flag not captured");
	run_cov_c: cover property (@(posedge clk_sys) run_rise ##[1:20] run_fall);
	halt_cov_c: cover property (@(posedge clk_sys) st_ff.st == irc_pkg::IRC_HALTED);
	wake_cov_c: cover property (@(posedge clk_sys) st_ff.c.wake ##1 !st_ff.c.wake);
endmodule

/* logic/irc_top.sv */
// register file and four isochronous receive contexts
`timescale 1ns/1ps
//
// Functional notes
// - run bit starts and stops processing
// - run changes only by software or reset
// - bits 14 and 13 read zero
// - wake resumes descriptor processing
// - descriptor fetch clears wake
// - fatal error sets halt flag
// - clearing run clears halt flag
// - active shows descriptor processing
// - beta flag from physical layer
// - beta request gets beta response
// - bit 8 reads zero
// - speed code reports receive rate
// - fill mode limited event codes
// - fill mode backs out bad packets
// - per-buffer mode limited event codes
// - first descriptor from command pointer
// - four independent contexts
// - command pointer is read-only
// - set and clear addresses per context
module irc_top (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic sw_rst,
	input wire irc_pkg::irc_bus_req_t bus,
	output logic [31:0] rdata,
	input wire irc_pkg::irc_pkt_t pkt,
	input wire irc_pkg::irc_eng_t [3:0] eng,
	output logic [3:0] ctx_active,
	output logic [3:0] resp_beta
);
	typedef struct packed {
		logic [31:0] rdata;
	} irc_top_st_t;

	irc_top_st_t st_ff;
	irc_top_st_t nxt_st;
	irc_pkg::irc_ctx_t [3:0] ctx_q;
	irc_pkg::irc_state_t [3:0] state_q;
	logic [3:0] set_wr;
	logic [3:0] clr_wr;

	function automatic logic [11:0] ctx_base(input logic [1:0] n);
		ctx_base = irc_pkg::CTX_STRIDE * {10'h000, n};
	endfunction

	function automatic logic [31:0] ctl_word(input irc_pkg::irc_ctx_t c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[irc_pkg::BIT_FILL] = c.fill;
		w[irc_pkg::BIT_RUN] = c.run;
		w[irc_pkg::BIT_WAKE] = c.wake;
		w[irc_pkg::BIT_HALT] = c.halt;
		w[irc_pkg::BIT_ACTIVE] = c.active;
		w[irc_pkg::BIT_BETA] = c.beta;
		w[irc_pkg::SPD_LSB +: 3] = c.speed;
		w[irc_pkg::EVT_LSB +: 5] = c.evt;
		ctl_word = w;
	endfunction

	for (genvar i = 0; i < irc_pkg::NUM_CTX; i++) begin : g_ctx
		assign set_wr[i] = bus.wr &&
			bus.addr == irc_pkg::OFS_CTL_SET + ctx_base(2'(i));
		assign clr_wr[i] = bus.wr &&
			bus.addr == irc_pkg::OFS_CTL_CLR + ctx_base(2'(i));
		irc_ctx u_ctx (
			.clk_sys(clk_sys),
			.sys_rst(sys_rst),
			.sw_rst(sw_rst),
			.set_wr(set_wr[i]),
			.clr_wr(clr_wr[i]),
			.wdata(bus.wdata),
			.pkt(pkt.valid && pkt.ctx == 2'(i) ? pkt : '0),
			.eng(eng[i]),
			.ctx_q(ctx_q[i]),
			.state_q(state_q[i]),
			.resp_beta(resp_beta[i])
		);
		assign ctx_active[i] = ctx_q[i].active;
	end

	always_comb begin
		nxt_st.rdata = 32'h0000_0000;
		if (bus.rd) begin
			for (int i = 0; i < irc_pkg::NUM_CTX; i++) begin
				if (bus.addr == irc_pkg::OFS_CTL_SET + ctx_base(2'(i)) ||
						bus.addr == irc_pkg::OFS_CTL_CLR + ctx_base(2'(i)))
					nxt_st.rdata = ctl_word(ctx_q[i]);
				if (bus.addr == irc_pkg::OFS_CMD_PTR + ctx_base(2'(i)))
					nxt_st.rdata = ctx_q[i].ptr;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign rdata = st_ff.rdata;

	rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		rdata[14:13] == 2'b00 && rdata[8] == 1'b0 || rdata == ctx_q[0].ptr
		|| rdata == ctx_q[1].ptr || rdata == ctx_q[2].ptr || rdata == ctx_q[3].ptr)
		else $error("reserved bits read nonzero");
	ptr_ro_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(bus.wr && bus.addr == irc_pkg::OFS_CMD_PTR && !eng[0].ptr_load)
		|=> $stable(ctx_q[0].ptr))
		else $error("pointer changed by write");
	rd_cov_c: cover property (@(posedge clk_sys) bus.rd ##1 rdata != 32'h0000_0000);
endmodule

/* dv/irc_eng_model.sv */
// descriptor engine stand-in that turns bench requests into engine events
`timescale 1ns/1ps
module irc_eng_model (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [3:0] ctx_active,
	input wire logic [3:0] fetch_req,
	input wire logic [3:0] fatal_req,
	input wire logic [3:0] ptr_req,
	input wire logic [3:0] idle_req,
	output irc_pkg::irc_eng_t [3:0] eng
);
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < 4; i++) begin
			eng[i].fetch <= !sys_rst && fetch_req[i] && ctx_active[i];
			eng[i].fatal <= !sys_rst && fatal_req[i];
			eng[i].fatal_code <= irc_pkg::EVT_UNKNOWN;
			eng[i].idle <= !sys_rst && idle_req[i];
			eng[i].ptr <= 32'hC000_0000 | (32'(i) << 8);
			eng[i].ptr_load <= !sys_rst && ptr_req[i];
		end
	end
endmodule

/* dv/iso_rx_context_control_status_tb.sv */
// self-checking bench for the receive context control block
`timescale 1ns/1ps
module iso_rx_context_control_status_tb;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic sw_rst = 1'b0;
	irc_pkg::irc_bus_req_t bus = '0;
	irc_pkg::irc_pkt_t pkt = '0;
	irc_pkg::irc_eng_t [3:0] eng;
	logic [31:0] rdata;
	logic [3:0] ctx_active;
	logic [3:0] resp_beta;
	logic [3:0] fetch_req = 4'h0;
	logic [3:0] fatal_req = 4'h0;
	logic [3:0] ptr_req = 4'h0;
	logic [3:0] idle_req = 4'h0;
	int num_errors = 0;
	int check_count = 0;
	int seed = 58;
	int c, e, k;
	logic [2:0] spd;
	logic bt;

	irc_top u_irc_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .sw_rst(sw_rst), .bus(bus),
		.rdata(rdata), .pkt(pkt), .eng(eng), .ctx_active(ctx_active), .resp_beta(resp_beta));
	irc_eng_model u_irc_eng_model (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.ctx_active(ctx_active), .fetch_req(fetch_req), .fatal_req(fatal_req),
		.ptr_req(ptr_req), .idle_req(idle_req), .eng(eng));

	function automatic logic [11:0] adr(input int n, input logic [11:0] ofs);
		return ofs + 12'(n * 32);
	endfunction
	function automatic logic [4:0] pb_code(input int x);
		case (x)
			1: return irc_pkg::ACK_DATA_ERROR;
			2: return irc_pkg::EVT_OVERRUN;
			3: return irc_pkg::EVT_LONG_PACKET;
			default: return irc_pkg::ACK_COMPLETE;
		endcase
	endfunction
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
		input string name);
		logic [31:0] got;
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		@(negedge clk_sys);
		got = rdata;
		@(posedge clk_sys);
		chk(name, x, got & m);
	endtask
	task automatic send(input int n, input logic b, input logic [2:0] s, input int x);
		pkt <= '{1'b1, n[1:0], b, s, x == 4, x == 1, x == 2, x == 3};
		@(posedge clk_sys);
		pkt.valid <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		report_and_stop();
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		for (c = 0; c < 4; c++) begin
			rd(adr(c, irc_pkg::OFS_CTL_SET), 32'hFFFF_FFFF, 32'h0, "ctl_reset");
			wr(adr(c, irc_pkg::OFS_CTL_SET), 32'h0000_EFFF);
			rd(adr(c, irc_pkg::OFS_CTL_CLR), 32'h0000_FFFF, 32'h0000_8400, "ctl_run");
			chk("active_vec", 32'((1 << (c + 1)) - 1), 32'(ctx_active));
		end
		wr(adr(1, irc_pkg::OFS_CTL_SET), 32'h0000_1000);
		rd(adr(1, irc_pkg::OFS_CTL_SET), 32'h0000_1000, 32'h0000_1000, "wake_set");
		fetch_req <= 4'h2;
		@(posedge clk_sys);
		fetch_req <= 4'h0;
		repeat (3) @(posedge clk_sys);
		rd(adr(1, irc_pkg::OFS_CTL_SET), 32'h0000_1000, 32'h0, "wake_fetch");
		for (k = 0; k < 16; k++) begin
			c = $unsigned($random(seed)) % 4;
			spd = (k == 0) ? irc_pkg::SPD_800 : 3'($unsigned($random(seed)) % 4);
			bt = $random(seed);
			e = $unsigned($random(seed)) % 4;
			send(c, bt, spd, e);
			rd(adr(c, irc_pkg::OFS_CTL_SET), 32'h0000_02FF,
				(32'(bt) << 9) | (32'(spd) << 5) | 32'(pb_code(e)), "pkt_status");
			chk("resp_beta", 32'(bt), 32'(resp_beta[c]));
		end
		idle_req <= 4'h8;
		repeat (3) @(posedge clk_sys);
		idle_req <= 4'h0;
		repeat (2) @(posedge clk_sys);
		rd(adr(3, irc_pkg::OFS_CTL_SET), 32'h0000_0400, 32'h0, "idle_stop");
		wr(adr(3, irc_pkg::OFS_CTL_SET), 32'h0000_1000);
		rd(adr(3, irc_pkg::OFS_CTL_SET), 32'h0000_8400, 32'h0000_8400, "wake_resume");
		fatal_req <= 4'h4;
		@(posedge clk_sys);
		fatal_req <= 4'h0;
		repeat (3) @(posedge clk_sys);
		rd(adr(2, irc_pkg::OFS_CTL_SET), 32'h0000_881F, 32'h0000_880E, "fatal");
		wr(adr(2, irc_pkg::OFS_CTL_CLR), 32'h0000_8000);
		rd(adr(2, irc_pkg::OFS_CTL_SET), 32'h0000_8C00, 32'h0, "run_clear");
		ptr_req <= 4'h4;
		@(posedge clk_sys);
		ptr_req <= 4'h0;
		repeat (3) @(posedge clk_sys);
		wr(adr(2, irc_pkg::OFS_CMD_PTR), 32'hFFFF_FFFF);
		rd(adr(2, irc_pkg::OFS_CMD_PTR), 32'hFFFF_FFFF, 32'hC000_0200, "cmd_ptr");
		wr(adr(0, irc_pkg::OFS_CMD_PTR), 32'hFFFF_FFFF);
		rd(adr(0, irc_pkg::OFS_CMD_PTR), 32'hFFFF_FFFF, irc_pkg::CMD_PTR_RESET, "cmd_ptr_ro");
		rd(12'h7F0, 32'hFFFF_FFFF, 32'h0, "unmapped");
		wr(adr(2, irc_pkg::OFS_CTL_SET), 32'h8000_0000);
		wr(adr(2, irc_pkg::OFS_CTL_SET), 32'h0000_8000);
		for (e = 1; e < 5; e++) begin
			send(2, 1'b0, irc_pkg::SPD_400, e == 3 ? 0 : e);
		end
		send(2, 1'b0, irc_pkg::SPD_400, 0);
		rd(adr(2, irc_pkg::OFS_CTL_SET), 32'h8000_001F, 32'h8000_0011, "fill_evt");
		send(2, 1'b0, irc_pkg::SPD_400, 1);
		rd(adr(2, irc_pkg::OFS_CTL_SET), 32'h8000_001F, 32'h8000_0011, "fill_bad");
		sw_rst <= 1'b1;
		@(posedge clk_sys);
		sw_rst <= 1'b0;
		@(posedge clk_sys);
		rd(adr(0, irc_pkg::OFS_CTL_SET), 32'h0000_9C00, 32'h0, "sw_reset");
		chk("active_off", 32'h0, 32'(ctx_active));
		report_and_stop();
	end
endmodule
